/* File: inc/sad_pkg.sv */
// servo alarm detector constants: register map, alarm codes, timing
// assumes a 20 MHz core clock and an Avalon-MM register bus with 32-bit data
package sad_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_ALARM    = 4'h0;
    localparam logic [3:0] ADDR_STATUS   = 4'h4;
    localparam logic [3:0] ADDR_MASK     = 4'h8;
    localparam logic [3:0] ADDR_CFG_A    = 4'hC;
    localparam logic [3:0] ADDR_CFG_B    = 4'h0;
    // second page: address bit 4 set
    localparam logic [3:0] ADDR_CFG_C    = 4'h4;
    localparam logic [3:0] ADDR_LOG_ADDR = 4'h8;
    localparam logic [3:0] ADDR_LOG_DATA = 4'hC;

    // two-digit alarm codes, held as BCD
    localparam logic [7:0] ALM_NONE      = 8'h00;
    localparam logic [7:0] ALM_GEAR      = 8'h27;
    localparam logic [7:0] ALM_OVERRUN   = 8'h34;
    localparam logic [7:0] ALM_PARAM_ERR = 8'h36;
    localparam logic [7:0] ALM_PARAM_BAD = 8'h37;
    localparam logic [7:0] ALM_TRAVEL    = 8'h38;
    localparam logic [7:0] ALM_ANALOG1   = 8'h39;
    localparam logic [7:0] ALM_ONE_TURN  = 8'h44;
    localparam logic [7:0] ALM_MULTI     = 8'h45;
    localparam logic [7:0] ALM_ENC_FAULT = 8'h46;
    localparam logic [7:0] ALM_ENC_MOVE  = 8'h47;
    localparam logic [7:0] ALM_INDEX     = 8'h48;
    localparam logic [7:0] ALM_SERIAL    = 8'h49;
    localparam logic [7:0] ALM_CPU1      = 8'h58;
    localparam logic [7:0] ALM_CPU2      = 8'h60;
    localparam logic [7:0] ALM_CPU3      = 8'h61;
    localparam logic [7:0] ALM_CPU4      = 8'h62;
    localparam logic [7:0] ALM_CPU5      = 8'h63;
    localparam logic [7:0] ALM_ANALOG2   = 8'h65;

    // event bit positions in status and mask
    localparam int EV_N = 18;
    localparam int EV_GEAR = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_PARAM_ERR = 2;
    localparam int EV_PARAM_BAD = 3;
    localparam int EV_TRAVEL = 4;
    localparam int EV_ANALOG1 = 5;
    localparam int EV_ONE_TURN = 6;
    localparam int EV_MULTI = 7;
    localparam int EV_ENC_FAULT = 8;
    localparam int EV_ENC_MOVE = 9;
    localparam int EV_INDEX = 10;
    localparam int EV_SERIAL = 11;
    localparam int EV_CPU0 = 12;
    localparam int EV_ANALOG2 = 17;
    localparam int CPU_N = 5;

    // gear limit: 500 kpps command rate
    localparam int RATE_LIMIT_KPPS = 500;
    localparam int CLK_HZ = 20000000;
    localparam logic [31:0] RATE_LIMIT_PPS = 32'(RATE_LIMIT_KPPS * 1000);
    // rate measurement window of 1 ms
    localparam int RATE_WIN_US = 1000;
    localparam logic [15:0] RATE_WIN_CYC = 16'(CLK_HZ / 1000000 * RATE_WIN_US);
    // pulses per window at the limit
    localparam logic [31:0] RATE_LIMIT_WIN = 32'(RATE_LIMIT_KPPS * RATE_WIN_US / 1000);

    // power-on check window after reset release
    localparam logic [7:0] POWERON_CYC = 8'h10;
    // default index timeout (cycles), above 4096 so it is a top parameter
    localparam int INDEX_TIMEOUT_DEF = 200000;

    // reset values of configuration fields
    localparam logic [15:0] GEAR_NUMER_RST = 16'h0001;
    localparam logic [15:0] GEAR_DENOM_RST = 16'h0001;
    localparam logic [15:0] THRESH_RST    = 16'h7FFF;
    localparam logic [15:0] OVERRUN_RST   = 16'h0000;
    localparam logic [1:0]  TBSEL_RST     = 2'h0;
    localparam logic [EV_N-1:0] MASK_RST  = '0;
    localparam logic [3:0]  LOG_DEPTH_LOG2 = 4'h4;
endpackage

/* File: logic/sad_alarm_log.sv */
// small memory holding the first 16 alarm codes seen since reset
// assumes one write port from the detector and one registered read port
`timescale 1ns/1ps
module sad_alarm_log (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:15];

    // contents need no reset; the valid count lives in the detector
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: logic/sad_detector.sv */
// servo alarm detector: watches parameters, limits, analog inputs, encoder
// status and self-checks, latches the first alarm code, Avalon-MM slave
// assumes pins are asynchronous to core_clk; analog values arrive as sampled words
`timescale 1ns/1ps
// Summary of operation
// - a command while the gear numerator pushes the command rate above 500 kpps raises alarm 27.
// - a data error in the parameters read at power-on raises alarm 36.
// - a corrupt parameter block at power-on raises alarm 37, separate from alarm 36.
// - both travel-prohibit inputs inactive together at power-on or in operation raise alarm 38.
// - the travel-block selection setting decides whether the prohibit check runs.
// - analog input 1 above the analog-excess threshold in operation raises alarm 39.
// - analog input 2 above the same threshold in operation raises alarm 65.
// - single-turn and multi-turn encoder counter faults at power-on raise alarms 44 and 45.
// - an encoder fault indication at power-on raises alarm 46.
// - absolute encoder status showing motion at power-up raises alarm 47.
// - a missing once-per-turn index pulse in operation raises alarm 48.
// - processor self-check failures at power-on raise alarms 58, 60, 61, 62 or 63.
module sad_detector #(
    parameter int INDEX_TIMEOUT = sad_pkg::INDEX_TIMEOUT_DEF
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic fwd_travel_block_in,
    input wire logic rev_travel_block_in,
    input wire logic cmd_pulse_in,
    input wire logic enc_index_in,
    input wire logic enc_position_serial,
    input wire logic [15:0] analog_cmd_1,
    input wire logic [15:0] analog_cmd_2,
    input wire logic [15:0] travel_position,
    input wire logic param_data_err,
    input wire logic param_corrupt,
    input wire logic enc_one_turn_fault,
    input wire logic enc_multi_turn_fault,
    input wire logic enc_link_fault,
    input wire logic enc_moving_at_power,
    input wire logic enc_serial_logic_err,
    input wire logic [4:0] cpu_check_fail,
    input wire logic run_active,
    output logic [7:0] alarm_code,
    output logic alarm_active
);
    // pin synchronisers, two flops each
    localparam int PIN_N = 4;
    logic [PIN_N-1:0] pin_s1, pin_s2, pin_s3;
    logic fwd_s, rev_s, cmd_s, idx_s, cmd_rise, idx_rise;
    always_ff @(posedge core_clk)
    begin
        pin_s1 <= {enc_index_in, cmd_pulse_in, rev_travel_block_in, fwd_travel_block_in};
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end
    assign fwd_s = pin_s2[0];
    assign rev_s = pin_s2[1];
    assign cmd_s = pin_s2[2];
    assign idx_s = pin_s2[3];
    assign cmd_rise = cmd_s & ~pin_s3[2];
    assign idx_rise = idx_s & ~pin_s3[3];

    // registers
    logic [sad_pkg::EV_N-1:0] status, mask, next_status, next_mask;
    logic [15:0] gear_numer_a, gear_numer_b, gear_denom, next_numer_a, next_numer_b, next_denom;
    logic [15:0] analog_excess_thresh_cfg, overrun_limit_cfg, next_thresh, next_overrun;
    logic [1:0] travel_block_select_cfg, next_tbsel;
    logic abs_encoder_op_select_cfg, next_abs_sel, gear_sel, next_gear_sel;
    logic [3:0] log_rd_addr, next_log_rd_addr;

    // power-on window and rate counters
    logic [7:0] pon_cnt, next_pon_cnt;
    logic [15:0] win_cnt, next_win_cnt;
    logic [31:0] pulse_cnt, next_pulse_cnt;
    logic [31:0] idx_cnt, next_idx_cnt;
    logic in_power_on;
    assign in_power_on = pon_cnt != sad_pkg::POWERON_CYC;

    // events
    logic [sad_pkg::EV_N-1:0] ev;
    logic [31:0] numer_sel, scaled_rate;
    logic travel_check_on;
    assign numer_sel = {16'h0000, gear_sel ? gear_numer_b : gear_numer_a};
    // scaled pulses this window = input pulses * numer / denom, compared without division
    assign scaled_rate = 32'(pulse_cnt * numer_sel);
    // selection 0: both inputs checked; 1: inputs disabled; others: checked
    assign travel_check_on = travel_block_select_cfg != 2'h1;

    always_comb
    begin
        ev = '0;
        ev[sad_pkg::EV_GEAR] = cmd_rise &&
            scaled_rate > 32'(sad_pkg::RATE_LIMIT_WIN * {16'h0000, gear_denom});
        ev[sad_pkg::EV_OVERRUN] = !in_power_on && run_active && overrun_limit_cfg != 16'h0000 &&
            travel_position > overrun_limit_cfg;
        ev[sad_pkg::EV_PARAM_ERR] = in_power_on && param_data_err;
        ev[sad_pkg::EV_PARAM_BAD] = in_power_on && param_corrupt;
        ev[sad_pkg::EV_TRAVEL] = travel_check_on && !fwd_s && !rev_s;
        ev[sad_pkg::EV_ANALOG1] = !in_power_on && run_active &&
            analog_cmd_1 > analog_excess_thresh_cfg;
        ev[sad_pkg::EV_ANALOG2] = !in_power_on && run_active &&
            analog_cmd_2 > analog_excess_thresh_cfg;
        ev[sad_pkg::EV_ONE_TURN] = in_power_on && abs_encoder_op_select_cfg && enc_one_turn_fault;
        ev[sad_pkg::EV_MULTI] = in_power_on && abs_encoder_op_select_cfg && enc_multi_turn_fault;
        ev[sad_pkg::EV_ENC_FAULT] = in_power_on && enc_link_fault;
        ev[sad_pkg::EV_ENC_MOVE] = in_power_on && abs_encoder_op_select_cfg && enc_moving_at_power;
        ev[sad_pkg::EV_INDEX] = !in_power_on && run_active &&
            idx_cnt >= 32'(INDEX_TIMEOUT);
        ev[sad_pkg::EV_SERIAL] = !in_power_on && run_active && enc_serial_logic_err;
        for (int i = 0; i < sad_pkg::CPU_N; i++)
        begin
            ev[sad_pkg::EV_CPU0 + i] = in_power_on && cpu_check_fail[i];
        end
    end

    // the serial line itself is watched only through enc_serial_logic_err; the raw
    // line is kept on the port so a later decoder can sit here
    logic unused_serial;
    assign unused_serial = enc_position_serial;

    function automatic logic [7:0] code_of(input logic [sad_pkg::EV_N-1:0] e);
        logic [7:0] c;
        c = sad_pkg::ALM_NONE;
        // lowest code number wins when several fire in one cycle
        if (e[sad_pkg::EV_ANALOG2]) c = sad_pkg::ALM_ANALOG2;
        if (e[sad_pkg::EV_CPU0 + 4]) c = sad_pkg::ALM_CPU5;
        if (e[sad_pkg::EV_CPU0 + 3]) c = sad_pkg::ALM_CPU4;
        if (e[sad_pkg::EV_CPU0 + 2]) c = sad_pkg::ALM_CPU3;
        if (e[sad_pkg::EV_CPU0 + 1]) c = sad_pkg::ALM_CPU2;
        if (e[sad_pkg::EV_CPU0]) c = sad_pkg::ALM_CPU1;
        if (e[sad_pkg::EV_SERIAL]) c = sad_pkg::ALM_SERIAL;
        if (e[sad_pkg::EV_INDEX]) c = sad_pkg::ALM_INDEX;
        if (e[sad_pkg::EV_ENC_MOVE]) c = sad_pkg::ALM_ENC_MOVE;
        if (e[sad_pkg::EV_ENC_FAULT]) c = sad_pkg::ALM_ENC_FAULT;
        if (e[sad_pkg::EV_MULTI]) c = sad_pkg::ALM_MULTI;
        if (e[sad_pkg::EV_ONE_TURN]) c = sad_pkg::ALM_ONE_TURN;
        if (e[sad_pkg::EV_ANALOG1]) c = sad_pkg::ALM_ANALOG1;
        if (e[sad_pkg::EV_TRAVEL]) c = sad_pkg::ALM_TRAVEL;
        if (e[sad_pkg::EV_PARAM_BAD]) c = sad_pkg::ALM_PARAM_BAD;
        if (e[sad_pkg::EV_PARAM_ERR]) c = sad_pkg::ALM_PARAM_ERR;
        if (e[sad_pkg::EV_OVERRUN]) c = sad_pkg::ALM_OVERRUN;
        if (e[sad_pkg::EV_GEAR]) c = sad_pkg::ALM_GEAR;
        return c;
    endfunction

    // alarm latch and log
    logic [7:0] next_alarm_code, new_code;
    logic next_alarm_active;
    logic [3:0] log_wr_ptr, next_log_wr_ptr;
    logic [4:0] log_count, next_log_count;
    logic log_we;
    logic [7:0] log_rd_data;
    assign new_code = code_of(ev);
    assign log_we = |ev && (log_count != 5'h10);

    always_comb
    begin
        next_alarm_code = alarm_code;
        next_alarm_active = alarm_active;
        next_log_wr_ptr = log_wr_ptr;
        next_log_count = log_count;
        // first alarm sticks until reset; later ones only fill the log
        if (!alarm_active && |ev)
        begin
            next_alarm_code = new_code;
            next_alarm_active = 1'b1;
        end
        if (log_we)
        begin
            next_log_wr_ptr = log_wr_ptr + 4'h1;
            next_log_count = log_count + 5'h01;
        end
    end

    sad_alarm_log u_log (
        .core_clk(core_clk),
        .wr_en(log_we),
        .wr_addr(log_wr_ptr),
        .wr_data(new_code),
        .rd_addr(log_rd_addr),
        .rd_data(log_rd_data)
    );

    // counters
    always_comb
    begin
        next_pon_cnt = in_power_on ? pon_cnt + 8'h01 : pon_cnt;
        next_win_cnt = win_cnt + 16'h0001;
        next_pulse_cnt = cmd_rise ? pulse_cnt + 32'h00000001 : pulse_cnt;
        if (win_cnt == sad_pkg::RATE_WIN_CYC - 16'h0001)
        begin
            next_win_cnt = 16'h0000;
            next_pulse_cnt = 32'h00000000;
        end
        next_idx_cnt = (idx_rise || !run_active) ? 32'h00000000 : idx_cnt + 32'h00000001;
        if (idx_cnt >= 32'(INDEX_TIMEOUT))
        begin
            next_idx_cnt = idx_cnt;
        end
    end

    // bus: one wait cycle per access, answer on the second edge
    logic bus_ack, next_bus_ack;
    logic [31:0] next_readdata;
    logic next_wait;
    logic acc;
    logic is_rd_status;
    assign acc = (avs_read || avs_write) && !bus_ack;
    assign is_rd_status = avs_read && acc && avs_address == {1'b0, sad_pkg::ADDR_STATUS};

    always_comb
    begin
        next_bus_ack = acc;
        next_wait = !acc;
        next_readdata = avs_readdata;
        next_mask = mask;
        next_numer_a = gear_numer_a;
        next_numer_b = gear_numer_b;
        next_denom = gear_denom;
        next_thresh = analog_excess_thresh_cfg;
        next_overrun = overrun_limit_cfg;
        next_tbsel = travel_block_select_cfg;
        next_abs_sel = abs_encoder_op_select_cfg;
        next_gear_sel = gear_sel;
        next_log_rd_addr = log_rd_addr;
        // read clears status; a same-cycle event still sets its bit
        next_status = (is_rd_status ? '0 : status) | ev;
        if (acc && avs_read)
        begin
            unique case (avs_address)
                {1'b0, sad_pkg::ADDR_ALARM}: next_readdata = {23'h0, alarm_active, alarm_code};
                {1'b0, sad_pkg::ADDR_STATUS}: next_readdata = {14'h0, status};
                {1'b0, sad_pkg::ADDR_MASK}: next_readdata = {14'h0, mask};
                {1'b0, sad_pkg::ADDR_CFG_A}: next_readdata = {gear_numer_b, gear_numer_a};
                {1'b1, sad_pkg::ADDR_CFG_B}: next_readdata = {overrun_limit_cfg, gear_denom};
                {1'b1, sad_pkg::ADDR_CFG_C}: next_readdata = {12'h0, gear_sel, abs_encoder_op_select_cfg,
                    travel_block_select_cfg, analog_excess_thresh_cfg};
                {1'b1, sad_pkg::ADDR_LOG_ADDR}: next_readdata = {23'h0, log_count, log_rd_addr};
                {1'b1, sad_pkg::ADDR_LOG_DATA}: next_readdata = {24'h0, log_rd_data};
                default: next_readdata = 32'h00000000;
            endcase
        end
        if (acc && avs_write)
        begin
            unique case (avs_address)
                {1'b0, sad_pkg::ADDR_MASK}: next_mask = avs_writedata[sad_pkg::EV_N-1:0];
                {1'b0, sad_pkg::ADDR_CFG_A}:
                begin
                    next_numer_a = avs_writedata[15:0];
                    next_numer_b = avs_writedata[31:16];
                end
                {1'b1, sad_pkg::ADDR_CFG_B}:
                begin
                    next_denom = avs_writedata[15:0];
                    next_overrun = avs_writedata[31:16];
                end
                {1'b1, sad_pkg::ADDR_CFG_C}:
                begin
                    next_thresh = avs_writedata[15:0];
                    next_tbsel = avs_writedata[17:16];
                    next_abs_sel = avs_writedata[18];
                    next_gear_sel = avs_writedata[19];
                end
                {1'b1, sad_pkg::ADDR_LOG_ADDR}: next_log_rd_addr = avs_writedata[3:0];
                default: next_log_rd_addr = log_rd_addr;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            status <= '0;
            mask <= sad_pkg::MASK_RST;
            gear_numer_a <= sad_pkg::GEAR_NUMER_RST;
            gear_numer_b <= sad_pkg::GEAR_NUMER_RST;
            gear_denom <= sad_pkg::GEAR_DENOM_RST;
            analog_excess_thresh_cfg <= sad_pkg::THRESH_RST;
            overrun_limit_cfg <= sad_pkg::OVERRUN_RST;
            travel_block_select_cfg <= sad_pkg::TBSEL_RST;
            abs_encoder_op_select_cfg <= 1'b1;
            gear_sel <= 1'b0;
            log_rd_addr <= 4'h0;
            pon_cnt <= 8'h00;
            win_cnt <= 16'h0000;
            pulse_cnt <= 32'h00000000;
            idx_cnt <= 32'h00000000;
            alarm_code <= sad_pkg::ALM_NONE;
            alarm_active <= 1'b0;
            log_wr_ptr <= 4'h0;
            log_count <= 5'h00;
            bus_ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            irq <= 1'b0;
        end
        else
        begin
            status <= next_status;
            mask <= next_mask;
            gear_numer_a <= next_numer_a;
            gear_numer_b <= next_numer_b;
            gear_denom <= next_denom;
            analog_excess_thresh_cfg <= next_thresh;
            overrun_limit_cfg <= next_overrun;
            travel_block_select_cfg <= next_tbsel;
            abs_encoder_op_select_cfg <= next_abs_sel;
            gear_sel <= next_gear_sel;
            log_rd_addr <= next_log_rd_addr;
            pon_cnt <= next_pon_cnt;
            win_cnt <= next_win_cnt;
            pulse_cnt <= next_pulse_cnt;
            idx_cnt <= next_idx_cnt;
            alarm_code <= next_alarm_code;
            alarm_active <= next_alarm_active;
            log_wr_ptr <= next_log_wr_ptr;
            log_count <= next_log_count;
            bus_ack <= next_bus_ack;
            avs_waitrequest <= next_wait;
            avs_readdata <= next_readdata;
            irq <= |(next_status & next_mask);
        end
    end

    // assertions
    sequence s_first_alarm;
        !alarm_active && |ev;
    endsequence
    a_first_code_held: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_first_alarm |=> alarm_active && alarm_code == $past(new_code))
        else $error("first alarm code not latched");
    a_code_stays_put: assert property (@(posedge core_clk) disable iff (!reset_n)
        alarm_active |=> alarm_code == $past(alarm_code))
        else $error("latched alarm code changed");
    a_travel_both_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!fwd_s && !rev_s && travel_block_select_cfg == 2'h0) |=> status[sad_pkg::EV_TRAVEL])
        else $error("travel prohibit alarm missing");
    a_travel_disabled: assert property (@(posedge core_clk) disable iff (!reset_n)
        travel_block_select_cfg == 2'h1 |-> !ev[sad_pkg::EV_TRAVEL])
        else $error("travel alarm while check disabled");
    a_analog1_excess: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!in_power_on && run_active && analog_cmd_1 > analog_excess_thresh_cfg) |=> status[sad_pkg::EV_ANALOG1])
        else $error("analog 1 excess not flagged");
    a_analog2_excess: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!in_power_on && run_active && analog_cmd_2 > analog_excess_thresh_cfg) |=> status[sad_pkg::EV_ANALOG2])
        else $error("analog 2 excess not flagged");
    a_overrun_zero_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        overrun_limit_cfg == 16'h0000 |-> !ev[sad_pkg::EV_OVERRUN])
        else $error("overrun alarm with limit zero");
    a_param_err_pon: assert property (@(posedge core_clk) disable iff (!reset_n)
        (in_power_on && param_data_err) |=> status[sad_pkg::EV_PARAM_ERR])
        else $error("parameter data error not flagged");
    a_param_bad_code: assert property (@(posedge core_clk) disable iff (!reset_n)
        (in_power_on && param_corrupt && !param_data_err && !alarm_active && !cmd_rise && !ev[sad_pkg::EV_OVERRUN]
        && !ev[sad_pkg::EV_TRAVEL]) |=> alarm_code == sad_pkg::ALM_PARAM_BAD)
        else $error("corrupt parameter code wrong");
    a_cpu_pon_only: assert property (@(posedge core_clk) disable iff (!reset_n)
        (in_power_on && cpu_check_fail != 5'h00) |=>
        (status[sad_pkg::EV_CPU0 +: sad_pkg::CPU_N] & $past(cpu_check_fail)) == $past(cpu_check_fail))
        else $error("self-check failure not flagged");
    a_index_timeout: assert property (@(posedge core_clk) disable iff (!reset_n)
        (run_active && !in_power_on && idx_cnt >= 32'(INDEX_TIMEOUT)) |=> status[sad_pkg::EV_INDEX])
        else $error("index pulse loss not flagged");
    a_encoder_pon: assert property (@(posedge core_clk) disable iff (!reset_n)
        (in_power_on && abs_encoder_op_select_cfg && enc_one_turn_fault) |=> status[sad_pkg::EV_ONE_TURN])
        else $error("one-turn counter fault not flagged");
endmodule

/* File: bench/sad_far_side.sv */
// far-side model: travel limit sensors, encoder index and command pulse source
// assumes the bench commands the faults; pins change just after core_clk rises
`timescale 1ns/1ps
module sad_far_side (
    input wire logic core_clk,
    input wire logic limits_off,
    input wire logic index_on,
    output logic fwd_travel_block_in = 1'b1,
    output logic rev_travel_block_in = 1'b1,
    output logic enc_index_in = 1'b0,
    output logic cmd_pulse_in = 1'b0
);
    logic [5:0] tick = 6'h00;
    // one pulse per 64 cycles is 312 kpps, under the rate limit at unity gear
    always_ff @(posedge core_clk)
    begin
        tick <= tick + 6'h01;
        fwd_travel_block_in <= !limits_off;
        rev_travel_block_in <= !limits_off;
        enc_index_in <= index_on && tick == 6'h00;
        cmd_pulse_in <= tick == 6'h20;
    end
endmodule

/* File: bench/servo_alarm_detector_tb.sv */
// self-checking bench: one reset per case, then the fault that should be latched
// assumes the far-side model drives limits, index and command pulses
`timescale 1ns/1ps
module servo_alarm_detector_tb;
    localparam logic [7:0] EXP [19] = '{8'h36, 8'h37, 8'h44, 8'h45, 8'h46, 8'h47, 8'h58, 8'h60, 8'h61, 8'h62,
        8'h63, 8'h49, 8'h39, 8'h38, 8'h48, 8'h65, 8'h27, 8'h34, 8'h00};
    logic core_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, lim_off = 1'b0, idx_on = 1'b1;
    logic run_on = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
    logic avs_waitrequest, irq, fwd_travel_block_in, rev_travel_block_in, enc_index_in, cmd_pulse_in, alarm_active;
    logic [7:0] alarm_code;
    logic [15:0] analog_cmd_1 = 16'h0000, analog_cmd_2 = 16'h0000, travel_position = 16'h0000;
    logic [11:0] ev = 12'h000;
    int fails = 0, comparisons = 0;
    sad_detector #(.INDEX_TIMEOUT(100)) uut (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .fwd_travel_block_in, .rev_travel_block_in,
        .cmd_pulse_in, .enc_index_in, .enc_position_serial(1'b0), .analog_cmd_1, .analog_cmd_2, .travel_position,
        .param_data_err(ev[0]), .param_corrupt(ev[1]), .enc_one_turn_fault(ev[2]), .enc_multi_turn_fault(ev[3]),
        .enc_link_fault(ev[4]), .enc_moving_at_power(ev[5]), .cpu_check_fail(ev[10:6]),
        .enc_serial_logic_err(ev[11]), .run_active(run_on), .alarm_code, .alarm_active);
    sad_far_side far (.core_clk, .limits_off(lim_off), .index_on(idx_on), .fwd_travel_block_in,
        .rev_travel_block_in, .enc_index_in, .cmd_pulse_in);
    task automatic report_and_stop();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request is held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
        if (n == 50)
        begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic run(input int c);
        int n;
        logic sel;
        n = 0;
        sel = 1'($urandom);
        reset_n <= 1'b0;
        ev <= c < 12 ? 12'h001 << c : 12'h000;
        analog_cmd_1 <= 16'($urandom) & 16'h7FFF;
        analog_cmd_2 <= 16'($urandom) & 16'h7FFF;
        travel_position <= 16'($urandom);
        lim_off <= c == 13;
        idx_on <= c != 14;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        if (c == 12) analog_cmd_1 <= 16'h8000 | 16'($urandom);
        if (c == 15) analog_cmd_2 <= 16'h8000 | 16'($urandom);
        if (c == 16) bus(1'b1, 5'h14, {12'h0, sel, 3'h4, 16'h7FFF});
        if (c == 16) bus(1'b1, 5'h0C, sel ? 32'hFFFF0001 : 32'h0001FFFF);
        if (c == 17) bus(1'b1, 5'h10, 32'h00100001);
        if (c == 17) travel_position <= 16'h0011 + 16'($urandom & 32'hFF);
        if (c == 18) bus(1'b1, 5'h14, 32'h00057FFF);
        if (c == 18) lim_off <= 1'b1;
        if (c == 18) run_on <= 1'b0;
        if (c == 18) analog_cmd_1 <= 16'hFFFF;
        while (alarm_active !== 1'b1 && n < 400)
        begin
            n++;
            @(posedge core_clk);
        end
        chk({24'h0, alarm_code}, {24'h0, EXP[c]});
        if (c == 12)
        begin
            analog_cmd_1 <= 16'h0000;
            bus(1'b0, 5'h08, 32'h0);
            chk(rd, 32'h0);
            bus(1'b1, 5'h08, 32'h00000020);
            bus(1'b0, 5'h00, 32'h0);
            chk({rd[8:0], 22'h0, irq}, {9'h139, 22'h0, 1'b1});
            bus(1'b0, 5'h04, 32'h0);
            chk(rd, 32'h00000020);
            bus(1'b0, 5'h04, 32'h0);
            chk(rd, 32'h0);
            bus(1'b0, 5'h05, 32'h0);
            chk({rd[31:1], irq}, 32'h0);
        end
        run_on <= 1'b1;
        analog_cmd_1 <= 16'h0000;
        analog_cmd_2 <= 16'hFFFF;
        repeat (10) @(posedge core_clk);
        chk({24'h0, alarm_code}, {24'h0, EXP[c] == 8'h00 ? 8'h65 : EXP[c]});
        $display("test %0d done", c);
    endtask
    initial
    begin
        forever #25 core_clk = !core_clk;
    end
    initial
    begin
        void'($urandom(32'hBFC028F9));
        for (int c = 0; c < 19; c++)
            run(c);
        report_and_stop();
    end
endmodule
